// file: hdl/acs_pkg.sv
// constants, encodings and tables for the conversion sequencer
package acs_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned DELAY_STEP_US = 2000;
  localparam int unsigned ADC_DW = 20;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] CONFIG_OFF = 8'h00;
  localparam logic [7:0] ADC_CONFIG_OFF = 8'h04;
  localparam logic [7:0] SHUNT_CAL_OFF = 8'h08;
  localparam logic [7:0] SHUNT_RES_OFF = 8'h0C;
  localparam logic [7:0] BUS_RES_OFF = 8'h10;
  localparam logic [7:0] TEMP_RES_OFF = 8'h14;
  localparam logic [7:0] CURRENT_OFF = 8'h18;
  localparam logic [7:0] POWER_OFF = 8'h1C;
  localparam logic [7:0] ENERGY_OFF = 8'h20;
  localparam logic [7:0] CHARGE_OFF = 8'h24;
  localparam logic [7:0] DIAG_ALERT_OFF = 8'h28;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int unsigned MODE_LSB = 12;
  localparam int unsigned MODE_CONT_BIT = 15;
  localparam int unsigned BUS_CT_LSB = 9;
  localparam int unsigned SHUNT_CT_LSB = 6;
  localparam int unsigned TEMP_CT_LSB = 3;
  localparam int unsigned AVG_LSB = 0;
  localparam int unsigned FLAG_BIT = 1;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [15:0] ADC_CONFIG_RST = 16'hFB68;
  localparam logic [14:0] SHUNT_CAL_RST = 15'h0000;

  // ****************************************
  // channels and states
  // ****************************************
  localparam logic [1:0] CH_SHUNT = 2'h0;
  localparam logic [1:0] CH_BUS = 2'h1;
  localparam logic [1:0] CH_TEMP = 2'h2;
  localparam logic [1:0] CH_NONE = 2'h3;

  typedef enum logic [1:0] {ST_OFF, ST_DELAY, ST_CONV} acs_state_e;

  // conversion period in microseconds per code
  function automatic int unsigned ct_us(input logic [2:0] code);
    case (code)
      3'h0: ct_us = 50;
      3'h1: ct_us = 84;
      3'h2: ct_us = 150;
      3'h3: ct_us = 280;
      3'h4: ct_us = 540;
      3'h5: ct_us = 1052;
      3'h6: ct_us = 2074;
      default: ct_us = 4120;
    endcase
  endfunction : ct_us

  // averaging count is one shifted left by this amount
  function automatic logic [3:0] avg_shift(input logic [2:0] code);
    case (code)
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      3'h4: avg_shift = 4'h7;
      3'h5: avg_shift = 4'h8;
      3'h6: avg_shift = 4'h9;
      default: avg_shift = 4'hA;
    endcase
  endfunction : avg_shift

  // first enabled channel at or after start, CH_NONE if none
  function automatic logic [1:0] next_chan(input logic [2:0] en, input logic [1:0] start);
    next_chan = CH_NONE;
    for (int i = 2; i >= 0; i--)
    begin
      if (en[i] && (2'(i) >= start))
      begin
        next_chan = 2'(i);
      end
    end
  endfunction : next_chan

endpackage : acs_pkg

// file: hdl/acs_avg_if.sv
// averaging accumulator connection between sequencer and accumulator
interface acs_avg_if #(parameter int unsigned DW = 20);
  logic add;
  logic clear;
  logic [1:0] chan;
  logic signed [DW-1:0] sample;
  logic [3:0] shift;
  logic signed [DW-1:0] avg [3];

  modport seq (output add, output clear, output chan, output sample, output shift, input avg);
  modport acc (input add, input clear, input chan, input sample, input shift, output avg);
endinterface : acs_avg_if

// file: hdl/acs_avg_acc.sv
// per-channel averaging accumulators
module acs_avg_acc
  import acs_pkg::*;
#(
  parameter int unsigned DW = ADC_DW
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  acs_avg_if.acc a
);

  localparam int unsigned AW = DW + 10;

  // ****************************************
  // one accumulator per measured input
  // ****************************************
  for (genvar i = 0; i < 3; i++)
  begin : g_ch
    logic signed [AW-1:0] acc_q;
    logic signed [AW-1:0] shifted;

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        acc_q <= '0;
      else if (ce)
      begin
        if (a.clear)
          acc_q <= '0;
        else if (a.add && (a.chan == 2'(i)))
          acc_q <= acc_q + AW'(a.sample);
      end
    end

    assign shifted = acc_q >>> a.shift;
    assign a.avg[i] = shifted[DW-1:0];
  end

endmodule : acs_avg_acc

// file: hdl/acs_seq_top.sv
// conversion sequencer with apb register file and result math
//
// Chosen here: the register offsets and the APB slave port.

// Notes on behaviour
// R1: mode field selects shunt, bus, temperature
// R2: shunt samples are signed, both directions
// R3: without averaging each result loads at once
// R4: separate conversion period per input
// R5: enabled inputs convert one after another
// R6: averaging accumulates, outputs load at count
// R7: results hold until next complete result; averaged load zeroes results of disabled inputs
// R8: continuous mode repeats sequence forever
// R9: triggered mode runs once then shuts down
// R10: mode write aborts and restarts conversion
// R11: done flag set after whole sequence
// R12: flag clears on diag read, non-shutdown setup write
// R13: current, power, charge, energy in background
// R14: host ignores accumulation in triggered mode
// R15: start delay in 2 ms steps, default zero
// R16: filter follows selected conversion period
// R17: averaging count shared by all inputs
// R18: power uses latest current and bus
// R19: zero calibration reports zero power, charge
// R20: energy and charge accumulate, not averaged
// R21: start delay only after mode write
// R22: accumulator cleared after each average
module acs_seq_top
  import acs_pkg::*;
#(
  parameter int unsigned CYCLES_PER_US = CLK_MHZ,
  parameter int unsigned DW = ADC_DW
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [DW-1:0] adc_sample,
  output logic [1:0] adc_mux_sel,
  output logic [2:0] adc_rate,
  output logic adc_run,
  output logic conversion_done_flag
);

  // ****************************************
  // state
  // ****************************************
  acs_state_e st_q, st_d;
  logic [1:0] chan_q, chan_d;
  logic [31:0] timer_q, timer_d;
  logic [9:0] pass_q, pass_d;
  logic load_q;
  logic flag_q;
  logic [7:0] cfg_q;
  logic [15:0] adc_cfg_q;
  logic [14:0] cal_q;
  logic signed [DW-1:0] shunt_res_q, bus_res_q, temp_res_q, current_q, last_cur_q;
  logic signed [23:0] power_q;
  logic [31:0] energy_q, charge_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic [1:0] mux_q;
  logic [2:0] rate_q;
  logic run_q;

  acs_avg_if #(.DW(DW)) avg_i ();

  acs_avg_acc #(.DW(DW)) u_acc (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .a(avg_i.acc)
  );

  // ****************************************
  // apb decode
  // ****************************************
  logic access, wr_done, rd_done, cfg_wr, diag_rd, mapped;
  assign access = psel && penable && !pready_q;
  assign wr_done = psel && penable && pready_q && pwrite && !pslverr_q;
  assign rd_done = psel && penable && pready_q && !pwrite;
  assign cfg_wr = wr_done && (paddr == ADC_CONFIG_OFF);
  assign diag_rd = rd_done && (paddr == DIAG_ALERT_OFF);
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= DIAG_ALERT_OFF);

  // new setting takes effect in the same cycle as its write
  logic [15:0] cfg_new;
  logic [2:0] en_w;
  logic cont_w;
  logic [3:0] shift_w;
  logic [9:0] avg_last;
  logic single;
  assign cfg_new = cfg_wr ? pwdata[15:0] : adc_cfg_q;
  // R1: input enables from mode field
  assign en_w = cfg_new[MODE_LSB+:3];
  assign cont_w = cfg_new[MODE_CONT_BIT];
  // R17: one count for every input
  assign shift_w = avg_shift(cfg_new[AVG_LSB+:3]);
  assign avg_last = 10'((11'h001 << shift_w) - 11'h001);
  assign single = (shift_w == 4'h0);

  // R4: period per input, counted in clock cycles
  function automatic logic [2:0] ct_code(input logic [15:0] c, input logic [1:0] ch);
    case (ch)
      CH_SHUNT: ct_code = c[SHUNT_CT_LSB+:3];
      CH_BUS: ct_code = c[BUS_CT_LSB+:3];
      default: ct_code = c[TEMP_CT_LSB+:3];
    endcase
  endfunction : ct_code

  function automatic logic [31:0] ct_load(input logic [15:0] c, input logic [1:0] ch);
    ct_load = 32'(ct_us(ct_code(c, ch)) * CYCLES_PER_US) - 32'h1;
  endfunction : ct_load

  logic [1:0] first_ch, follow_ch;
  logic [31:0] delay_load;
  logic conv_end, seq_end, final_pass;
  assign first_ch = next_chan(en_w, CH_SHUNT);
  assign follow_ch = next_chan(en_w, 2'(chan_q + 2'h1));
  // R15: delay steps of 2 ms, zero means none
  assign delay_load = 32'(32'(cfg_q) * DELAY_STEP_US * CYCLES_PER_US) - 32'h1;
  assign conv_end = (st_q == ST_CONV) && (timer_q == 32'h0) && !cfg_wr;
  assign seq_end = conv_end && (follow_ch == CH_NONE);
  assign final_pass = seq_end && (pass_q == avg_last);

  // ****************************************
  // sequencer
  // ****************************************
  always_comb
  begin
    st_d = st_q;
    chan_d = chan_q;
    timer_d = timer_q;
    pass_d = pass_q;
    // R10: setup write aborts and restarts
    if (cfg_wr)
    begin
      pass_d = 10'h000;
      chan_d = first_ch;
      if (en_w == 3'h0)
        st_d = ST_OFF;
      // R21: delay applied only here
      else if (cfg_q != 8'h00)
      begin
        st_d = ST_DELAY;
        timer_d = delay_load;
      end
      else
      begin
        st_d = ST_CONV;
        timer_d = ct_load(cfg_new, first_ch);
      end
    end
    else
    begin
      case (st_q)
        ST_OFF: st_d = ST_OFF;
        ST_DELAY:
        begin
          if (timer_q != 32'h0)
            timer_d = timer_q - 32'h1;
          else
          begin
            st_d = ST_CONV;
            chan_d = first_ch;
            timer_d = ct_load(cfg_new, first_ch);
          end
        end
        ST_CONV:
        begin
          if (timer_q != 32'h0)
            timer_d = timer_q - 32'h1;
          // R5: step to next enabled input
          else if (follow_ch != CH_NONE)
          begin
            chan_d = follow_ch;
            timer_d = ct_load(cfg_new, follow_ch);
          end
          else
          begin
            // R6: repeat sequence until count reached
            pass_d = final_pass ? 10'h000 : 10'(pass_q + 10'h001);
            chan_d = first_ch;
            timer_d = ct_load(cfg_new, first_ch);
            // R9: last averaging pass then shutdown
            // R8: continuous mode loops
            if (final_pass && !cont_w)
              st_d = ST_OFF;
          end
        end
        default: st_d = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= ST_OFF;
      chan_q <= CH_SHUNT;
      timer_q <= 32'h0;
      pass_q <= 10'h000;
      load_q <= 1'b0;
    end
    else if (ce)
    begin
      st_q <= st_d;
      chan_q <= chan_d;
      timer_q <= timer_d;
      pass_q <= pass_d;
      load_q <= final_pass && !single;
    end
  end

  // ****************************************
  // averaging and result math
  // ****************************************
  // R22: clear after each average and on restart
  assign avg_i.clear = load_q || cfg_wr;
  assign avg_i.add = conv_end && !single;
  assign avg_i.chan = chan_q;
  // R2: signed shunt samples
  assign avg_i.sample = adc_sample;
  assign avg_i.shift = shift_w;

  // R13: math runs beside conversion, no extra time
  logic signed [DW-1:0] cur_src, bus_src, cur_now, pwr_cur;
  logic signed [DW+15:0] cur_prod;
  logic signed [2*DW:0] pwr_prod;
  logic signed [23:0] pwr_now;
  assign cur_src = load_q ? avg_i.avg[0] : adc_sample;
  assign bus_src = load_q ? avg_i.avg[1] : adc_sample;
  assign cur_prod = cur_src * $signed({1'b0, cal_q});
  assign cur_now = cur_prod[DW+14:15];
  // R18: latest current times latest bus voltage
  assign pwr_cur = load_q ? cur_now : last_cur_q;
  assign pwr_prod = pwr_cur * $signed({1'b0, bus_src});
  assign pwr_now = pwr_prod[2*DW-1:2*DW-24];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shunt_res_q <= '0;
      bus_res_q <= '0;
      temp_res_q <= '0;
      current_q <= '0;
      last_cur_q <= '0;
      power_q <= '0;
      energy_q <= 32'h0;
      charge_q <= 32'h0;
    end
    else if (ce)
    begin
      // R20: accumulate every conversion, not averaged
      if (conv_end && (chan_q == CH_SHUNT))
      begin
        last_cur_q <= cur_now;
        charge_q <= charge_q + 32'(cur_now);
      end
      if (conv_end && (chan_q == CH_BUS))
        energy_q <= energy_q + 32'(pwr_now);
      // R3: immediate per-input update
      if (conv_end && single)
      begin
        case (chan_q)
          CH_SHUNT:
          begin
            shunt_res_q <= adc_sample;
            current_q <= cur_now;
          end
          CH_BUS:
          begin
            bus_res_q <= adc_sample;
            power_q <= pwr_now;
          end
          default: temp_res_q <= adc_sample;
        endcase
      end
      // R7: outputs change on complete results; averaged load also zeroes disabled inputs
      if (load_q)
      begin
        shunt_res_q <= avg_i.avg[0];
        bus_res_q <= avg_i.avg[1];
        temp_res_q <= avg_i.avg[2];
        current_q <= cur_now;
        power_q <= pwr_now;
      end
    end
  end

  // ****************************************
  // registers and bus answer
  // ****************************************
  logic flag_set, flag_clr, cal_zero;
  // R11: set once sequence and averaging finish
  assign flag_set = (final_pass && single) || load_q;
  // R12: diag read or non-shutdown setup write
  assign flag_clr = diag_rd || (cfg_wr && (en_w != 3'h0));
  // R19: zero calibration hides power, energy and charge
  assign cal_zero = (cal_q == 15'h0000);

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    case (paddr)
      CONFIG_OFF: rd_mux = {24'h0, cfg_q};
      ADC_CONFIG_OFF: rd_mux = {16'h0, adc_cfg_q};
      SHUNT_CAL_OFF: rd_mux = {17'h0, cal_q};
      SHUNT_RES_OFF: rd_mux = 32'({1'b0, shunt_res_q});
      BUS_RES_OFF: rd_mux = 32'({1'b0, bus_res_q});
      TEMP_RES_OFF: rd_mux = 32'({1'b0, temp_res_q});
      CURRENT_OFF: rd_mux = 32'({1'b0, current_q});
      POWER_OFF: rd_mux = cal_zero ? 32'h0 : {8'h0, power_q};
      ENERGY_OFF: rd_mux = cal_zero ? 32'h0 : energy_q;
      CHARGE_OFF: rd_mux = cal_zero ? 32'h0 : charge_q;
      DIAG_ALERT_OFF: rd_mux = 32'(flag_q) << FLAG_BIT;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q <= CONFIG_RST;
      adc_cfg_q <= ADC_CONFIG_RST;
      cal_q <= SHUNT_CAL_RST;
      flag_q <= 1'b0;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      mux_q <= CH_SHUNT;
      rate_q <= 3'h0;
      run_q <= 1'b0;
    end
    else if (ce)
    begin
      pready_q <= access;
      pslverr_q <= access && !mapped;
      if (access)
        prdata_q <= pwrite ? 32'h0 : rd_mux;
      if (wr_done && (paddr == CONFIG_OFF))
        cfg_q <= pwdata[7:0];
      if (cfg_wr)
        adc_cfg_q <= pwdata[15:0];
      if (wr_done && (paddr == SHUNT_CAL_OFF))
        cal_q <= pwdata[14:0];
      if (flag_set)
        flag_q <= 1'b1;
      else if (flag_clr)
        flag_q <= 1'b0;
      mux_q <= chan_d;
      // R16: filter rate follows the active period
      rate_q <= ct_code(cfg_new, chan_d);
      run_q <= (st_d == ST_CONV);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign adc_mux_sel = mux_q;
  assign adc_rate = rate_q;
  assign adc_run = run_q;
  assign conversion_done_flag = flag_q;

endmodule : acs_seq_top

// file: tb/acs_adc_model.sv
// behavioural converter front end feeding samples to the sequencer
module acs_adc_model
  import acs_pkg::*;
#(
  parameter int SH = 0,
  parameter int BU = 0,
  parameter int TP = 0
)
(
  input wire logic pclk,
  input wire logic adc_run,
  input wire logic [1:0] adc_mux_sel,
  input wire logic [ADC_DW-1:0] offs,
  output logic signed [ADC_DW-1:0] adc_sample
);
  initial adc_sample = 20'h5A5A5;
  always @(posedge pclk)
  begin
    if (!adc_run)
      adc_sample <= ~adc_sample;
    else if (adc_mux_sel == CH_SHUNT)
      adc_sample <= ADC_DW'(SH) + offs;
    else if (adc_mux_sel == CH_BUS)
      adc_sample <= ADC_DW'(BU) + offs;
    else
      adc_sample <= ADC_DW'(TP) + offs;
  end
endmodule : acs_adc_model

// file: tb/acs_seq_top_asserts.sv
// port assertions for the conversion sequencer
module acs_seq_top_asserts
  import acs_pkg::*;
#(
  parameter int unsigned DW = ADC_DW
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic signed [DW-1:0] adc_sample,
  input wire logic [1:0] adc_mux_sel,
  input wire logic [2:0] adc_rate,
  input wire logic adc_run,
  input wire logic conversion_done_flag
);
  // ****************************************
  // setup shadow
  // ****************************************
  logic [15:0] cfg_q;
  wire cfg_wr = psel && penable && pready && pwrite && (paddr == ADC_CONFIG_OFF);
  wire [2:0] rate_exp = (adc_mux_sel == CH_SHUNT) ? cfg_q[8:6] :
                        (adc_mux_sel == CH_BUS) ? cfg_q[11:9] : cfg_q[5:3];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_q <= ADC_CONFIG_RST;
    else if (cfg_wr)
      cfg_q <= pwdata[15:0];
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_done(logic [7:0] a, logic w);
    psel && penable && pready && (pwrite == w) && (paddr == a);
  endsequence
  sequence s_steady_run;
    adc_run && !$past(cfg_wr) && !$past(cfg_wr, 2);
  endsequence

  AST_READY_WAIT: assert property (psel && penable && !pready && ce |=> pready)
    else $error("access not answered after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RUN_ENABLED: assert property (
    s_steady_run |-> (adc_mux_sel != CH_NONE) && cfg_q[MODE_LSB + adc_mux_sel])
    else $error("converting an input that is not enabled");
  AST_RATE: assert property (s_steady_run |-> adc_rate == rate_exp)
    else $error("period code does not match converted input");
  AST_SHUTDOWN: assert property (cfg_wr && pwdata[14:12] == 3'h0 |-> ##[1:3] !adc_run)
    else $error("converter still running after shutdown write");
  AST_DIAG_CLR: assert property (s_done(DIAG_ALERT_OFF, 1'b0) |=> !conversion_done_flag)
    else $error("flag not cleared by status read");
  AST_DIAG_DATA: assert property (
    s_done(DIAG_ALERT_OFF, 1'b0) |-> prdata[FLAG_BIT] == conversion_done_flag)
    else $error("status read disagrees with flag");
  AST_CFG_CLR: assert property (
    s_done(ADC_CONFIG_OFF, 1'b1) ##0 (pwdata[14:12] != 3'h0) |=> !conversion_done_flag)
    else $error("flag not cleared by setup write");
  AST_CFG_KEEP: assert property (
    s_done(ADC_CONFIG_OFF, 1'b1) ##0 (pwdata[14:12] == 3'h0) ##0 conversion_done_flag
    |=> conversion_done_flag)
    else $error("flag cleared by shutdown write");
  AST_FLAG_SET: assert property (
    $rose(conversion_done_flag) |-> $past(adc_run) || $past(adc_run, 2))
    else $error("flag set without a finished conversion");
endmodule : acs_seq_top_asserts

// file: tb/acs_seq_top_tb.sv
// self-checking bench for the conversion sequencer
module acs_seq_top_tb;
  import acs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SH = 64000;
  localparam int BU = 3000;
  localparam int CUR = (SH * 16384) >> 15;
  localparam int PWR = (CUR * BU) >> 16;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, adc_run, conversion_done_flag, er;
  logic [1:0] adc_mux_sel;
  logic [2:0] adc_rate;
  logic [ADC_DW-1:0] offs = 20'h00000;
  logic signed [ADC_DW-1:0] adc_sample;
  int n_mismatch = 0, checked = 0, n;

  always #25 pclk = ~pclk;

  acs_seq_top #(.CYCLES_PER_US(1)) i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_sample(adc_sample),
    .adc_mux_sel(adc_mux_sel), .adc_rate(adc_rate), .adc_run(adc_run),
    .conversion_done_flag(conversion_done_flag));
  acs_adc_model #(.SH(SH), .BU(BU), .TP(77)) i_adc (.pclk(pclk), .adc_run(adc_run),
    .adc_mux_sel(adc_mux_sel), .offs(offs), .adc_sample(adc_sample));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv, e);
  endtask : rdc

  task automatic wf(input int lo, input int hi);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (conversion_done_flag !== 1'b1 && n < 3000);
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask : wf

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    chk(conversion_done_flag, 32'h0);
    rdc(CONFIG_OFF, 32'h0);
    rdc(ADC_CONFIG_OFF, 32'(ADC_CONFIG_RST));
    apb(1'b0, 8'h2C, 32'h0);
    chk(er, 32'h1);
    chk(rv, 32'h0);
    apb(1'b0, 8'h06, 32'h0);
    chk(er, 32'h1);
  endtask : t_regs

  task automatic t_trig();
    apb(1'b1, SHUNT_CAL_OFF, 32'h4000);
    apb(1'b1, ADC_CONFIG_OFF, 32'h3000);
    wf(98, 106);
    repeat (5) @(posedge pclk);
    chk(adc_run, 32'h0);
    rdc(SHUNT_RES_OFF, 32'(SH));
    rdc(BUS_RES_OFF, 32'(BU));
    rdc(CURRENT_OFF, 32'(CUR));
    rdc(POWER_OFF, 32'(PWR));
    // triggered totals hold one sequence only
    rdc(ENERGY_OFF, 32'(PWR));
    rdc(CHARGE_OFF, 32'(CUR));
    apb(1'b1, SHUNT_RES_OFF, 32'h5);
    rdc(SHUNT_RES_OFF, 32'(SH));
    rdc(DIAG_ALERT_OFF, 32'h2);
    rdc(DIAG_ALERT_OFF, 32'h0);
  endtask : t_trig

  task automatic t_avg();
    offs <= 20'hEEE90;
    apb(1'b1, ADC_CONFIG_OFF, 32'h1000);
    wf(48, 56);
    rdc(SHUNT_RES_OFF, 32'h000FE890);
    offs <= 20'h00000;
    apb(1'b1, ADC_CONFIG_OFF, 32'h1001);
    repeat (100) @(posedge pclk);
    rdc(SHUNT_RES_OFF, 32'h000FE890);
    wf(92, 104);
    rdc(SHUNT_RES_OFF, 32'(SH));
    rdc(CURRENT_OFF, 32'(CUR));
    apb(1'b1, ADC_CONFIG_OFF, 32'h9001);
    wf(196, 206);
    rdc(DIAG_ALERT_OFF, 32'h2);
    wf(190, 206);
    rdc(SHUNT_RES_OFF, 32'(SH));
  endtask : t_avg

  task automatic t_abort();
    apb(1'b1, ADC_CONFIG_OFF, 32'h1000);
    repeat (30) @(posedge pclk);
    apb(1'b1, ADC_CONFIG_OFF, 32'h1000);
    wf(48, 56);
  endtask : t_abort

  task automatic t_cont();
    apb(1'b1, ADC_CONFIG_OFF, 32'h9000);
    wf(48, 56);
    rdc(DIAG_ALERT_OFF, 32'h2);
    wf(40, 56);
    apb(1'b1, ADC_CONFIG_OFF, 32'h8000);
    repeat (3) @(posedge pclk);
    chk({conversion_done_flag, adc_run}, 32'h2);
  endtask : t_cont

  task automatic t_delay();
    apb(1'b1, CONFIG_OFF, 32'h1);
    apb(1'b1, ADC_CONFIG_OFF, 32'h9000);
    wf(2048, 2056);
    rdc(DIAG_ALERT_OFF, 32'h2);
    wf(40, 56);
    apb(1'b1, ADC_CONFIG_OFF, 32'h8000);
    apb(1'b1, CONFIG_OFF, 32'h0);
  endtask : t_delay

  task automatic t_cal0();
    apb(1'b1, SHUNT_CAL_OFF, 32'h0);
    apb(1'b1, ADC_CONFIG_OFF, 32'h7200);
    wf(182, 190);
    rdc(TEMP_RES_OFF, 32'h0000004D);
    rdc(POWER_OFF, 32'h0);
    rdc(ENERGY_OFF, 32'h0);
    rdc(CHARGE_OFF, 32'h0);
  endtask : t_cal0

  task automatic give_verdict();
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_trig();
    t_avg();
    t_abort();
    t_cont();
    t_delay();
    t_cal0();
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    give_verdict();
  end
endmodule : acs_seq_top_tb

bind acs_seq_top acs_seq_top_asserts #(.DW(DW)) i_chk (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_sample(adc_sample),
  .adc_mux_sel(adc_mux_sel), .adc_rate(adc_rate), .adc_run(adc_run),
  .conversion_done_flag(conversion_done_flag));
